// >>> verilog/txo_top.sv
// transmit slot tags, context tags, ordering queue and output stage
`include "txo_cfg.svh"

// ----------------------------------------------------------------------------
// message queue
// ----------------------------------------------------------------------------
module txo_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = `TXO_FIFO_DEPTH
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  // depth must be a power of two so that the pointers wrap by themselves
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic          in_ready_ff;
  logic [CW-1:0] nxt_count;
  wire           push = i_in_valid & in_ready_ff;
  wire           pop  = i_out_ready & o_out_valid;

  assign nxt_count   = CW'(count_ff + CW'(push) - CW'(pop));
  assign o_in_ready  = in_ready_ff;
  assign o_out_valid = (count_ff != '0);
  assign o_out_data  = mem[rd_ptr_ff];

  always_ff @(posedge i_clk) begin
    if (i_ce & push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      in_ready_ff <= `TXO_BIT_RST;
    end else if (i_ce) begin
      wr_ptr_ff   <= PW'(wr_ptr_ff + PW'(push));
      rd_ptr_ff   <= PW'(rd_ptr_ff + PW'(pop));
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != CW'(DEPTH));
    end
  end
endmodule

// Functional notes
// - queue space is held by the transmit slot tag of the sending task
// - a starting task gets a default transmit slot tag from the free list
// - sending a message gives back the sender's transmit slot tag
// - a tag request reports failure when no tag is free
// - with reordering on, a tag returns only after delivery to its destination
// - the number of transmit slot tags is a build-time parameter
// - a second ordered message with the same context tag stalls in the ordering queue
// - a missing sequence number stalls reordered output indefinitely
// - with duplicate sequence numbers only one passes, the rest stall
// - sequence ordering applies unless the bypass flag is set
// - a delivered self-addressed message becomes a task spawn request (the code raises it only while i_loopback_en is set)
module txo_top
  import txo_pkg::*;
#(
  parameter int NUM_TRANSMIT_SLOT_TAG   = `TXO_NUM_TRANSMIT_SLOT_TAG,
  parameter int NUM_CID    = `TXO_NUM_CID,
  parameter int SEQ_W      = `TXO_SEQ_W,
  parameter int DST_W      = `TXO_DST_W,
  parameter int TASK_W     = `TXO_TASK_W,
  parameter int DATA_W     = `TXO_DATA_W,
  parameter int FIFO_DEPTH = `TXO_FIFO_DEPTH,
  localparam int TAG_W     = $clog2(NUM_TRANSMIT_SLOT_TAG),
  localparam int CID_W     = $clog2(NUM_CID)
) (
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_ce,
  input  wire logic              i_seq_reorder_en,
  input  wire logic              i_cid_reorder_en,
  input  wire logic              i_loopback_en,
  input  wire logic [DST_W-1:0]  i_self_id,
  input  wire logic              i_task_start,
  output logic                   o_start_done,
  output logic                   o_start_ok,
  output logic [TAG_W-1:0]       o_start_tag,
  input  wire logic              i_txalloc_req,
  output logic                   o_txalloc_done,
  output logic                   o_txalloc_ok,
  output logic [TAG_W-1:0]       o_txalloc_tag,
  input  wire logic              i_cidalloc_req,
  output logic                   o_cidalloc_done,
  output logic                   o_cidalloc_ok,
  output logic [CID_W-1:0]       o_cidalloc_tag,
  input  wire logic              i_snd_valid,
  output logic                   o_snd_ready,
  input  wire logic [TAG_W-1:0]  i_snd_tag,
  input  wire logic [CID_W-1:0]  i_snd_cid,
  input  wire txo_opt_t          i_snd_opts,
  input  wire logic [SEQ_W-1:0]  i_snd_seq,
  input  wire logic [DST_W-1:0]  i_snd_dst,
  input  wire logic [TASK_W-1:0] i_snd_task,
  input  wire logic [DATA_W-1:0] i_snd_data,
  output logic                   o_msg_valid,
  input  wire logic              i_msg_ready,
  output logic [DST_W-1:0]       o_msg_dst,
  output logic [TASK_W-1:0]      o_msg_task,
  output logic [CID_W-1:0]       o_msg_cid,
  output logic [SEQ_W-1:0]       o_msg_seq,
  output logic [DATA_W-1:0]      o_msg_data,
  output logic                   o_spawn_valid,
  output logic [TASK_W-1:0]      o_spawn_task,
  output logic                   o_order_stall
);
  localparam int QW = 1 + `TXO_OPT_W + TAG_W + CID_W + SEQ_W + DST_W + TASK_W + DATA_W;

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  wire        rst_n = rst_sync_ff[1];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= '0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // --------------------------------------------------------------------------
  // free lists
  // --------------------------------------------------------------------------
  function automatic logic [TAG_W-1:0] first_tx(input logic [NUM_TRANSMIT_SLOT_TAG-1:0] v);
    logic [TAG_W-1:0] r;
    r = '0;
    for (int i = NUM_TRANSMIT_SLOT_TAG - 1; i >= 0; i--) begin
      if (v[i]) r = TAG_W'(i);
    end
    return r;
  endfunction

  function automatic logic [CID_W-1:0] first_cid(input logic [NUM_CID-1:0] v);
    logic [CID_W-1:0] r;
    r = '0;
    for (int i = NUM_CID - 1; i >= 0; i--) begin
      if (v[i]) r = CID_W'(i);
    end
    return r;
  endfunction

  logic [NUM_TRANSMIT_SLOT_TAG-1:0] free_tx_ff;
  logic [NUM_CID-1:0]  free_cid_ff;
  logic                late_ff;
  logic                relcid_ff;
  logic [TAG_W-1:0]    out_tag_ff;

  // tag count fixed by NUM_TRANSMIT_SLOT_TAG at build time
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] one_tx    = {{(NUM_TRANSMIT_SLOT_TAG-1){1'b0}}, 1'b1};
  wire [NUM_CID-1:0]  one_cid   = {{(NUM_CID-1){1'b0}}, 1'b1};
  wire                start_ok  = |free_tx_ff;
  wire [TAG_W-1:0]    start_tag = first_tx(free_tx_ff);
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] start_oh  = (i_task_start & start_ok) ? (one_tx << start_tag) : '0;
  // task start has priority; the software request sees what it leaves
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] left_tx   = free_tx_ff & ~start_oh;
  wire                alloc_ok  = |left_tx;
  wire [TAG_W-1:0]    alloc_tag = first_tx(left_tx);
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] alloc_oh  = (i_txalloc_req & alloc_ok) ? (one_tx << alloc_tag) : '0;
  wire                cid_ok    = |free_cid_ff;
  wire [CID_W-1:0]    cid_tag   = first_cid(free_cid_ff);
  wire [NUM_CID-1:0]  cid_oh    = (i_cidalloc_req & cid_ok) ? (one_cid << cid_tag) : '0;

  wire reo_any = i_seq_reorder_en | i_cid_reorder_en;
  wire snd_acc = i_snd_valid & o_snd_ready;
  wire deliver = o_msg_valid & i_msg_ready;

  // early release at acceptance, late release at delivery when reordering
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] rel_early = (snd_acc & ~reo_any) ? (one_tx << i_snd_tag) : '0;
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] rel_late  = (deliver & late_ff) ? (one_tx << out_tag_ff) : '0;
  wire [NUM_CID-1:0]  rel_cid   = (deliver & relcid_ff) ? (one_cid << o_msg_cid) : '0;

  // release is ored in last so it wins over any allocation
  wire [NUM_TRANSMIT_SLOT_TAG-1:0] nxt_free_tx  = (free_tx_ff & ~start_oh & ~alloc_oh) | rel_early | rel_late;
  wire [NUM_CID-1:0]  nxt_free_cid = (free_cid_ff & ~cid_oh) | rel_cid;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      free_tx_ff  <= {NUM_TRANSMIT_SLOT_TAG{`TXO_FREE_RST}};
      free_cid_ff <= {NUM_CID{`TXO_FREE_RST}};
    end else if (i_ce) begin
      free_tx_ff  <= nxt_free_tx;
      free_cid_ff <= nxt_free_cid;
    end
  end

  // status answers, one cycle after the request
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_start_done    <= `TXO_BIT_RST;
      o_start_ok      <= `TXO_BIT_RST;
      o_start_tag     <= '0;
      o_txalloc_done  <= `TXO_BIT_RST;
      o_txalloc_ok    <= `TXO_BIT_RST;
      o_txalloc_tag   <= '0;
      o_cidalloc_done <= `TXO_BIT_RST;
      o_cidalloc_ok   <= `TXO_BIT_RST;
      o_cidalloc_tag  <= '0;
    end else if (i_ce) begin
      o_start_done    <= i_task_start;
      o_start_ok      <= i_task_start & start_ok;
      o_start_tag     <= start_tag;
      o_txalloc_done  <= i_txalloc_req;
      o_txalloc_ok    <= i_txalloc_req & alloc_ok;
      o_txalloc_tag   <= alloc_tag;
      o_cidalloc_done <= i_cidalloc_req;
      o_cidalloc_ok   <= i_cidalloc_req & cid_ok;
      o_cidalloc_tag  <= cid_tag;
    end
  end

  // --------------------------------------------------------------------------
  // ordering queue
  // --------------------------------------------------------------------------
  logic [QW-1:0]     q_in;
  logic [QW-1:0]     q_out;
  logic              q_valid;
  logic              h_late;
  txo_opt_t          h_opts;
  logic [TAG_W-1:0]  h_tag;
  logic [CID_W-1:0]  h_cid;
  logic [SEQ_W-1:0]  h_seq;
  logic [DST_W-1:0]  h_dst;
  logic [TASK_W-1:0] h_task;
  logic [DATA_W-1:0] h_data;
  logic [SEQ_W-1:0]  exp_seq_ff;
  logic [CID_W-1:0]  exp_cid_ff;

  // the queue entry carries the tag that reserved it
  assign q_in = {reo_any, i_snd_opts, i_snd_tag, i_snd_cid, i_snd_seq, i_snd_dst, i_snd_task, i_snd_data};
  assign {h_late, h_opts, h_tag, h_cid, h_seq, h_dst, h_task, h_data} = q_out;

  // head waits for its turn; duplicates and gaps block everything behind
  wire seq_ord  = i_seq_reorder_en & ~h_opts[`TXO_OPT_SEQBYP];
  wire cid_ord  = i_cid_reorder_en & h_opts[`TXO_OPT_CIDORD];
  wire seq_wait = seq_ord & (h_seq != exp_seq_ff);
  wire cid_wait = cid_ord & (h_cid != exp_cid_ff);
  wire out_free = ~o_msg_valid | i_msg_ready;
  wire q_pop    = q_valid & ~seq_wait & ~cid_wait & out_free;

  txo_fifo #(
    .W     (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_ce        (i_ce),
    .i_in_valid  (i_snd_valid),
    .o_in_ready  (o_snd_ready),
    .i_in_data   (q_in),
    .o_out_valid (q_valid),
    .i_out_ready (q_pop),
    .o_out_data  (q_out)
  );

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_seq_ff    <= '0;
      exp_cid_ff    <= '0;
      o_order_stall <= `TXO_BIT_RST;
    end else if (i_ce) begin
      if (q_pop & seq_ord) exp_seq_ff <= SEQ_W'(exp_seq_ff + 1'b1);
      if (q_pop & cid_ord) exp_cid_ff <= CID_W'(exp_cid_ff + 1'b1);
      o_order_stall <= q_valid & (seq_wait | cid_wait);
    end
  end

  // --------------------------------------------------------------------------
  // output stage and spawn
  // --------------------------------------------------------------------------
  // self-addressed delivery only counts when the interconnect loops it back
  wire self_hit = deliver & i_loopback_en & (o_msg_dst == i_self_id);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_msg_valid   <= `TXO_BIT_RST;
      late_ff       <= `TXO_BIT_RST;
      relcid_ff     <= `TXO_BIT_RST;
      out_tag_ff    <= '0;
      o_msg_dst     <= '0;
      o_msg_task    <= '0;
      o_msg_cid     <= '0;
      o_msg_seq     <= '0;
      o_msg_data    <= '0;
      o_spawn_valid <= `TXO_BIT_RST;
      o_spawn_task  <= '0;
    end else if (i_ce) begin
      if (out_free) begin
        o_msg_valid <= q_pop;
        late_ff     <= h_late;
        relcid_ff   <= h_opts[`TXO_OPT_RELCID];
        out_tag_ff  <= h_tag;
        o_msg_dst   <= h_dst;
        o_msg_task  <= h_task;
        o_msg_cid   <= h_cid;
        o_msg_seq   <= h_seq;
        o_msg_data  <= h_data;
      end
      o_spawn_valid <= self_hit;
      o_spawn_task  <= o_msg_task;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_start_gets_tag: assert property (i_ce && i_task_start && (|free_tx_ff) |=> o_start_ok)
    else $error("starting task got no tag while tags were free");
  a_txalloc_fail_empty: assert property (i_ce && i_txalloc_req && (free_tx_ff == '0)
    |=> o_txalloc_done && !o_txalloc_ok)
    else $error("tag request did not fail with empty free list");
  a_alloc_removes_entry: assert property (i_ce && i_txalloc_req && alloc_ok
    |=> o_txalloc_ok && !free_tx_ff[o_txalloc_tag])
    else $error("granted tag still on free list");
  a_cid_status: assert property (i_ce && i_cidalloc_req |=> o_cidalloc_done && (o_cidalloc_ok == $past(cid_ok)))
    else $error("context tag status wrong");
  a_early_release: assert property (i_ce && snd_acc && !reo_any |=> free_tx_ff[$past(i_snd_tag)])
    else $error("tag not released on send");
  a_late_hold: assert property (i_ce && snd_acc && reo_any && !free_tx_ff[i_snd_tag]
    |=> !free_tx_ff[$past(i_snd_tag)])
    else $error("tag freed before delivery under reordering");
  a_seq_gap_stall: assert property (i_ce && q_valid && seq_wait && out_free
    |=> !o_msg_valid && o_order_stall)
    else $error("out of turn sequence number left the queue");
  a_bypass_passes: assert property (i_ce && q_valid && !seq_ord && !cid_wait && out_free
    |=> o_msg_valid && (o_msg_data == $past(h_data)))
    else $error("bypassed message held back");
  a_seq_advance: assert property (i_ce && q_pop && seq_ord |=> exp_seq_ff == SEQ_W'($past(exp_seq_ff) + 1'b1))
    else $error("expected sequence number did not advance");
  a_spawn_self: assert property (i_ce && self_hit
    |=> o_spawn_valid && (o_spawn_task == $past(o_msg_task)))
    else $error("self-addressed delivery raised no spawn");

  c_seq_stall: cover property (o_order_stall ##1 o_order_stall ##1 !o_order_stall);
  c_alloc_fail: cover property (o_txalloc_done && !o_txalloc_ok);
  c_spawn: cover property (o_spawn_valid);
  c_full_queue: cover property (!o_snd_ready);
endmodule

// >>> verilog/txo_cfg.svh
// constants for the transmit message bookkeeping block
`ifndef TXO_CFG_SVH
`define TXO_CFG_SVH

// send option bits
`define TXO_OPT_W       3
`define TXO_OPT_RELCID  0
`define TXO_OPT_CIDORD  1
`define TXO_OPT_SEQBYP  2

// default sizes
`define TXO_NUM_TRANSMIT_SLOT_TAG    16
`define TXO_NUM_CID     16
`define TXO_SEQ_W       8
`define TXO_DST_W       4
`define TXO_TASK_W      6
`define TXO_DATA_W      32
`define TXO_FIFO_DEPTH  8

// reset values
`define TXO_FREE_RST    1'b1
`define TXO_BIT_RST     1'b0

`endif

// >>> verilog/txo_pkg.sv
// types shared by the transmit message bookkeeping block
`include "txo_cfg.svh"

package txo_pkg;
  typedef logic [`TXO_OPT_W-1:0] txo_opt_t;
endpackage

// >>> testbench/txo_pe_model.sv
// far-side processing element that takes delivered messages
module txo_pe_model #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_hold,
  input  wire logic         i_slow,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] rx_q[$];
  logic         tick;
  initial begin
    o_ready = 1'b0;
    tick    = 1'b0;
  end
  // slow mode takes a word only every other cycle so the queue backs up
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      rx_q.push_back(i_data);
    end
    tick    <= ~tick;
    o_ready <= ~i_hold && (~i_slow || tick);
  end
endmodule

// >>> testbench/txo_top_tb.sv
// self-checking bench for the transmit message bookkeeping block
module txo_top_tb
  import txo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NTX   = 16;
  localparam int NCID  = 16;
  localparam int DEPTH = 8;
  logic        clk, arst_n, ce, seq_en, cid_en, lb_en, snd_valid, hold, slow, msg_ready;
  logic [2:0]  req;
  wire  [2:0]  done, ok;
  wire  [3:0]  tag_of [3];
  logic [3:0]  snd_tag, snd_cid, snd_dst, msg_dst, msg_cid;
  txo_opt_t    opts;
  logic [7:0]  snd_seq, msg_seq;
  logic [5:0]  snd_task, msg_task, spawn_task;
  logic [31:0] snd_data, msg_data;
  logic        snd_ready, msg_valid, spawn_valid, order_stall;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  txo_top #(.NUM_TRANSMIT_SLOT_TAG(NTX), .NUM_CID(NCID), .FIFO_DEPTH(DEPTH)) txo_top_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_seq_reorder_en(seq_en), .i_cid_reorder_en(cid_en),
    .i_loopback_en(lb_en), .i_self_id(4'h3), .i_task_start(req[0]), .o_start_done(done[0]),
    .o_start_ok(ok[0]), .o_start_tag(tag_of[0]), .i_txalloc_req(req[1]), .o_txalloc_done(done[1]),
    .o_txalloc_ok(ok[1]), .o_txalloc_tag(tag_of[1]), .i_cidalloc_req(req[2]), .o_cidalloc_done(done[2]),
    .o_cidalloc_ok(ok[2]), .o_cidalloc_tag(tag_of[2]), .i_snd_valid(snd_valid), .o_snd_ready(snd_ready),
    .i_snd_tag(snd_tag), .i_snd_cid(snd_cid), .i_snd_opts(opts), .i_snd_seq(snd_seq), .i_snd_dst(snd_dst),
    .i_snd_task(snd_task), .i_snd_data(snd_data), .o_msg_valid(msg_valid), .i_msg_ready(msg_ready),
    .o_msg_dst(msg_dst), .o_msg_task(msg_task), .o_msg_cid(msg_cid), .o_msg_seq(msg_seq),
    .o_msg_data(msg_data), .o_spawn_valid(spawn_valid), .o_spawn_task(spawn_task),
    .o_order_stall(order_stall));
  txo_pe_model #(.W(32)) txo_pe_model_inst (.i_clk(clk), .i_hold(hold), .i_slow(slow),
    .i_valid(msg_valid), .i_data(msg_data), .o_ready(msg_ready));

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a run that hangs on a handshake still ends with a verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic do_reset;
    arst_n <= 1'b0;
    seq_en <= 1'b0;
    cid_en <= 1'b0;
    repeat (20) @(posedge clk);
    chk("ready in reset", snd_ready, 1'b0);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // one-cycle request, answer polled after each edge since done stands one cycle
  task automatic alloc(input int k, input logic e_ok, input logic [3:0] e_tag, input string what);
    int w;
    @(posedge clk);
    req[k] <= 1'b1;
    @(posedge clk);
    req <= 3'h0;
    w = 0;
    #1;
    while (done[k] !== 1'b1 && w < 4) begin
      @(posedge clk);
      #1;
      w++;
    end
    chk(what, done[k], 1'b1);
    chk(what, ok[k], e_ok);
    if (e_ok) chk(what, tag_of[k], e_tag);
  endtask
  // called at an edge; valid stays up so back-to-back sends need no gap
  task automatic snd(input logic [3:0] tg, input logic [3:0] context_tag, input txo_opt_t op,
                     input logic [7:0] seq, input logic [3:0] dst, input logic [31:0] d, output bit acc);
    snd_valid <= 1'b1;
    snd_tag   <= tg;
    snd_cid   <= context_tag;
    opts      <= op;
    snd_seq   <= seq;
    snd_dst   <= dst;
    snd_task  <= d[5:0];
    snd_data  <= d;
    acc = 0;
    for (int i = 0; i < 12 && !acc; i++) begin
      @(posedge clk);
      acc = snd_ready;
    end
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 60 && txo_pe_model_inst.rx_q.size() < n; i++) @(posedge clk);
    chk("delivered count", txo_pe_model_inst.rx_q.size(), n);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic s_alloc;
    alloc(0, 1'b1, 4'h0, "default tag");
    for (int i = 1; i < NTX; i++) alloc(1, 1'b1, 4'(i), "tag request");
    alloc(1, 1'b0, 4'h0, "tag request empty");
    alloc(0, 1'b0, 4'h0, "default tag empty");
  endtask
  // a request made while the clock enable is low must not be answered
  task automatic s_freeze;
    @(posedge clk);
    ce     <= 1'b0;
    req[1] <= 1'b1;
    @(posedge clk);
    #1;
    chk("frozen request", done[1], 1'b0);
    @(posedge clk);
    req <= 3'h0;
    ce  <= 1'b1;
  endtask
  task automatic s_release;
    bit acc;
    txo_pe_model_inst.rx_q.delete();
    @(posedge clk);
    hold <= 1'b1;
    snd(4'h9, 4'h6, 3'h4, 8'h3c, 4'h1, 32'h0000_0a09, acc);
    snd_valid <= 1'b0;
    chk("send taken", acc, 1'b1);
    alloc(1, 1'b1, 4'h9, "tag back on send");
    chk("held at output", msg_valid, 1'b1);
    chk("message dst", msg_dst, 4'h1);
    chk("message cid", msg_cid, 4'h6);
    chk("message seq", msg_seq, 8'h3c);
    chk("message task", msg_task, 6'h09);
    @(posedge clk);
    hold <= 1'b0;
    wait_rx(1);
    chk("message data", txo_pe_model_inst.rx_q[0], 32'h0000_0a09);
  endtask
  task automatic s_seq;
    bit acc;
    txo_pe_model_inst.rx_q.delete();
    @(posedge clk);
    seq_en <= 1'b1;
    hold   <= 1'b1;
    snd(4'h4, 4'h0, 3'h4, 8'h55, 4'h1, 32'h0000_0b04, acc);
    snd_valid <= 1'b0;
    alloc(1, 1'b0, 4'h0, "tag kept until delivery");
    @(posedge clk);
    hold <= 1'b0;
    wait_rx(1);
    chk("bypass passes", txo_pe_model_inst.rx_q[0], 32'h0000_0b04);
    alloc(1, 1'b1, 4'h4, "tag after delivery");
    @(posedge clk);
    snd(4'h4, 4'h0, 3'h0, 8'h00, 4'h1, 32'h0000_0c00, acc);
    snd(4'h5, 4'h0, 3'h0, 8'h00, 4'h1, 32'h0000_0c01, acc);
    snd(4'h6, 4'h0, 3'h4, 8'h07, 4'h1, 32'h0000_0c02, acc);
    snd_valid <= 1'b0;
    repeat (12) @(posedge clk);
    chk("duplicate held back", txo_pe_model_inst.rx_q.size(), 2);
    chk("queue waits", order_stall, 1'b1);
    chk("nothing out", msg_valid, 1'b0);
    do_reset();
  endtask
  task automatic s_fill;
    bit acc;
    int n;
    n = 0;
    acc = 1;
    txo_pe_model_inst.rx_q.delete();
    @(posedge clk);
    hold <= 1'b1;
    while (acc && n < 12) begin
      snd(4'h1, 4'h0, 3'h4, 8'h00, 4'h1, 32'(n), acc);
      if (acc) n++;
    end
    snd_valid <= 1'b0;
    chk("queue capacity", n, DEPTH + 1);
    chk("ready low when full", snd_ready, 1'b0);
    @(posedge clk);
    hold <= 1'b0;
    slow <= 1'b1;
    wait_rx(DEPTH + 1);
    for (int i = 0; i <= DEPTH; i++) chk("drain order", txo_pe_model_inst.rx_q[i], 32'(i));
    chk("ready after drain", snd_ready, 1'b1);
    slow <= 1'b0;
  endtask
  task automatic s_ctx;
    bit acc;
    txo_pe_model_inst.rx_q.delete();
    alloc(2, 1'b1, 4'h0, "context tag");
    alloc(2, 1'b1, 4'h1, "context tag");
    @(posedge clk);
    snd(4'h2, 4'h0, 3'h1, 8'h00, 4'h1, 32'h0000_0d00, acc);
    snd_valid <= 1'b0;
    wait_rx(1);
    alloc(2, 1'b1, 4'h0, "context tag reused");
    for (int i = 2; i < NCID; i++) alloc(2, 1'b1, 4'(i), "context tag");
    alloc(2, 1'b0, 4'h0, "context tag empty");
    @(posedge clk);
    cid_en <= 1'b1;
    snd(4'h3, 4'h0, 3'h2, 8'h00, 4'h1, 32'h0000_0e00, acc);
    snd(4'h3, 4'h0, 3'h2, 8'h00, 4'h1, 32'h0000_0e01, acc);
    snd_valid <= 1'b0;
    repeat (12) @(posedge clk);
    chk("second context order held", txo_pe_model_inst.rx_q.size(), 2);
    chk("context queue waits", order_stall, 1'b1);
    do_reset();
  endtask
  task automatic s_spawn;
    bit acc;
    logic sp;
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk);
      lb_en <= k[0];
      snd(4'h5, 4'h0, 3'h4, 8'h00, 4'h3, 32'h0000_002a, acc);
      snd_valid <= 1'b0;
      sp = 1'b0;
      for (int i = 0; i < 20 && !sp; i++) begin
        @(posedge clk);
        #1;
        sp = spawn_valid;
      end
      chk("spawn raised", sp, k[0]);
      if (k == 1) chk("spawn task", spawn_task, 6'h2a);
    end
  endtask

  initial begin
    req       = 3'h0;
    snd_valid = 1'b0;
    {hold, slow, lb_en} = 3'h0;
    ce        = 1'b1;
    {snd_tag, snd_cid, snd_dst, snd_seq, snd_task, snd_data, opts} = '0;
    do_reset();
    s_alloc();
    s_freeze();
    s_release();
    s_seq();
    s_fill();
    s_ctx();
    s_spawn();
    summarize();
  end
endmodule
